// [srtc_sysref_cal.v]
// Operation
// - Enable bit 0: delay output follows the manual delay register.
// - Enable bit 1: delay output takes the calibrated value once complete, manual ignored.
// - Calibration starts only on a 0-to-1 change of the enable bit.
// - Averaging code 0..3 selects 4, 16, 64, 256 results; resets to 1.
// - Accumulation code 0..3 selects 4, 16, 64, 256 cycles; resets to 1.
// - A SYSREF period beyond the limit makes calibration fail.
// - Calibration ends within 384*19*4^(avg+acc+2) cycles.
// - Complete bit 17 sets once calibration finished with enable at 1.
// - Result bit 16 inversion, 15:8 coarse, 7:0 fine; valid when complete.
`timescale 1ns/100ps
`default_nettype none
`include "srtc_sysref_cal_map.vh"
module srtc_sysref_cal
#(
   parameter BOUND_BASE = `SRTC_BOUND_A * `SRTC_BOUND_B
)
(
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        wr_en_i,
   input  wire        rd_en_i,
   input  wire [11:0] addr_i,
   input  wire [7:0]  wdata_i,
   output reg  [7:0]  rdata_o,
   input  wire        sysref_i,
   output reg  [16:0] delay_o,
   output reg         cal_fail_o
);

   localparam ST_IDLE = 3'd0;
   localparam ST_EDGE = 3'd1;
   localparam ST_ACC  = 3'd2;
   localparam ST_NEXT = 3'd3;
   localparam ST_DONE = 3'd4;
   localparam ST_FAIL = 3'd5;
   localparam [3:0] EXP_OFS = `SRTC_BOUND_EXP_OFS;

   // Selects 4^(code+1), the count shared by averaging and accumulation.
   function [8:0] srtc_pow4;
      input [1:0] code;
      begin
         srtc_pow4 = 9'h004 << {code, 1'b0};
      end
   endfunction

   reg  [7:0]  enable_q;
   reg  [7:0]  config_q;
   reg  [16:0] manual_q;
   reg  [16:0] result_q;
   reg         complete_q;
   reg         en_prev_q;
   reg  [2:0]  state_q;
   reg  [8:0]  avg_left_q;
   reg  [16:0] sum_q;
   reg  [15:0] wait_q;
   reg  [31:0] run_q;
   reg  [7:0]  first_q;
   reg         first_seen_q;
   reg         sync1_q;
   reg         sync2_q;
   reg         sync3_q;

   wire        en_bit = enable_q[`SRTC_EN_BIT];
   wire [1:0]  avg_code = config_q[`SRTC_AVG_MSB:`SRTC_AVG_LSB];
   wire [1:0]  acc_code = config_q[`SRTC_ACC_MSB:`SRTC_ACC_LSB];
   wire        sys_rise = sync2_q & ~sync3_q;
   wire        acc_done;
   wire [8:0]  acc_count;
   wire        acc_start = (state_q == ST_EDGE) & sys_rise;
   reg  [15:0] period_max;
   wire [3:0]  exp_sh = {2'b00, avg_code} + {2'b00, acc_code} + EXP_OFS;
   wire [31:0] run_bound = BOUND_BASE << {exp_sh, 1'b0};
   wire [24:0] scaled = {sum_q, 8'h00} >> {exp_sh, 1'b0};
   wire [7:0]  fine = (scaled[24:8] != 17'h00000) ? 8'hff : scaled[7:0];

   always @*
   begin
      case (acc_code)
         2'd0: period_max = `SRTC_PERIOD_MAX0;
         2'd1: period_max = `SRTC_PERIOD_MAX1;
         2'd2: period_max = `SRTC_PERIOD_MAX2;
         default: period_max = `SRTC_PERIOD_MAX3;
      endcase
   end

   // Reference input passes two flip-flops; a third gives the edge.
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end
      else
      begin
         sync1_q <= sysref_i;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   srtc_accum
   #(
      .LEN_W (9),
      .CNT_W (9)
   )
   u_accum
   (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .start_i  (acc_start),
      .sample_i (sync2_q),
      .len_i    (srtc_pow4(acc_code)),
      .count_o  (acc_count),
      .done_o   (acc_done)
   );

   // Register writes.
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         enable_q <= `SRTC_ENABLE_RST;
         config_q <= `SRTC_CONFIG_RST;
         manual_q <= `SRTC_DELAY_RST;
      end
      else if (wr_en_i)
      begin
         case (addr_i)
            `SRTC_ADDR_ENABLE:  enable_q <= wdata_i;
            `SRTC_ADDR_CONFIG:  config_q <= wdata_i;
            `SRTC_ADDR_DELAY0:  manual_q[7:0] <= wdata_i;
            `SRTC_ADDR_DELAY1:  manual_q[15:8] <= wdata_i;
            `SRTC_ADDR_DELAY2:  manual_q[16] <= wdata_i[0];
            default: ;
         endcase
      end
   end

   // Register reads, registered one cycle after the strobe.
   always @(posedge clk_i)
   begin
      if (rst_i)
         rdata_o <= 8'h00;
      else if (rd_en_i)
      begin
         case (addr_i)
            `SRTC_ADDR_ENABLE:  rdata_o <= enable_q;
            `SRTC_ADDR_CONFIG:  rdata_o <= config_q;
            `SRTC_ADDR_STATUS0: rdata_o <= result_q[7:0];
            `SRTC_ADDR_STATUS1: rdata_o <= result_q[15:8];
            `SRTC_ADDR_STATUS2: rdata_o <= {6'h00, complete_q, result_q[16]};
            `SRTC_ADDR_DELAY0:  rdata_o <= manual_q[7:0];
            `SRTC_ADDR_DELAY1:  rdata_o <= manual_q[15:8];
            `SRTC_ADDR_DELAY2:  rdata_o <= {7'h00, manual_q[16]};
            default:            rdata_o <= 8'h00;
         endcase
      end
   end

   // Calibration sequence.
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         en_prev_q    <= 1'b0;
         state_q      <= ST_IDLE;
         avg_left_q   <= 9'h000;
         sum_q        <= 17'h00000;
         wait_q       <= 16'h0000;
         run_q        <= 32'h00000000;
         first_q      <= 8'h00;
         first_seen_q <= 1'b0;
         result_q     <= 17'h00000;
         complete_q   <= 1'b0;
         cal_fail_o   <= 1'b0;
      end
      else
      begin
         en_prev_q <= en_bit;
         run_q <= run_q + 32'h00000001;
         if (!en_bit)
         begin
            // Clearing the enable bit aborts a run and drops the status.
            state_q    <= ST_IDLE;
            complete_q <= 1'b0;
            cal_fail_o <= 1'b0;
         end
         else if (!en_prev_q)
         begin
            state_q      <= ST_EDGE;
            avg_left_q   <= srtc_pow4(avg_code);
            sum_q        <= 17'h00000;
            wait_q       <= 16'h0000;
            run_q        <= 32'h00000000;
            first_q      <= 8'h00;
            first_seen_q <= 1'b0;
            complete_q   <= 1'b0;
            cal_fail_o   <= 1'b0;
         end
         else if ((state_q == ST_EDGE || state_q == ST_ACC ||
                   state_q == ST_NEXT) && run_q >= run_bound)
            state_q <= ST_FAIL;
         else
         begin
            case (state_q)
               ST_EDGE:
               begin
                  if (!first_seen_q)
                     first_q <= first_q + 8'h01;
                  if (sys_rise)
                  begin
                     first_seen_q <= 1'b1;
                     wait_q       <= 16'h0000;
                     state_q      <= ST_ACC;
                  end
                  else if (first_seen_q && wait_q >= period_max)
                     state_q <= ST_FAIL;
                  else
                     wait_q <= wait_q + 16'h0001;
               end
               ST_ACC:
               begin
                  wait_q <= wait_q + 16'h0001;
                  if (acc_done)
                  begin
                     sum_q      <= sum_q + {8'h00, acc_count};
                     avg_left_q <= avg_left_q - 9'h001;
                     state_q    <= ST_NEXT;
                  end
               end
               ST_NEXT:
               begin
                  wait_q <= wait_q + 16'h0001;
                  if (avg_left_q == 9'h000)
                     state_q <= ST_DONE;
                  else
                     state_q <= ST_EDGE;
               end
               ST_DONE:
               begin
                  if (!complete_q)
                     result_q <= {fine[7], first_q, fine};
                  complete_q <= 1'b1;
               end
               ST_FAIL:
                  cal_fail_o <= 1'b1;
               default:
                  state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Delay output selection.
   always @(posedge clk_i)
   begin
      if (rst_i)
         delay_o <= `SRTC_DELAY_RST;
      else if (!en_bit)
         delay_o <= manual_q;
      else if (complete_q)
         delay_o <= result_q;
   end

endmodule // srtc_sysref_cal
`default_nettype wire

// [srtc_sysref_cal_map.vh]
`ifndef SRTC_SYSREF_CAL_MAP_VH
`define SRTC_SYSREF_CAL_MAP_VH
// Register byte addresses.
`define SRTC_ADDR_ENABLE   12'h2b0
`define SRTC_ADDR_CONFIG   12'h2b1
`define SRTC_ADDR_STATUS0  12'h2b2
`define SRTC_ADDR_STATUS1  12'h2b3
`define SRTC_ADDR_STATUS2  12'h2b4
`define SRTC_ADDR_DELAY0   12'h2b5
`define SRTC_ADDR_DELAY1   12'h2b6
`define SRTC_ADDR_DELAY2   12'h2b7
// Field positions.
`define SRTC_EN_BIT        0
`define SRTC_AVG_MSB       3
`define SRTC_AVG_LSB       2
`define SRTC_ACC_MSB       1
`define SRTC_ACC_LSB       0
`define SRTC_DONE_BIT      17
`define SRTC_INV_BIT       16
// Reset values.
`define SRTC_ENABLE_RST    8'h00
`define SRTC_CONFIG_RST    8'h05
`define SRTC_DELAY_RST     17'h00000
// Longest SYSREF period per accumulation code, in clock cycles.
`define SRTC_PERIOD_MAX0   16'd128
`define SRTC_PERIOD_MAX1   16'd1664
`define SRTC_PERIOD_MAX2   16'd7808
`define SRTC_PERIOD_MAX3   16'd32384
// Duration bound factors: 384 * 19 * 4^(avg + acc + 2).
`define SRTC_BOUND_A       384
`define SRTC_BOUND_B       19
`define SRTC_BOUND_EXP_OFS 2
`endif

// [srtc_accum.v]
`timescale 1ns/100ps
`default_nettype none
module srtc_accum
#(
   parameter LEN_W = 9,
   parameter CNT_W = 9
)
(
   input  wire             clk_i,
   input  wire             rst_i,
   input  wire             start_i,
   input  wire             sample_i,
   input  wire [LEN_W-1:0] len_i,
   output reg  [CNT_W-1:0] count_o,
   output reg              done_o
);

   reg [LEN_W-1:0] left_q;
   reg             busy_q;

   // Counts the cycles in which the sampled reference is high.
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         left_q  <= {LEN_W{1'b0}};
         busy_q  <= 1'b0;
         count_o <= {CNT_W{1'b0}};
         done_o  <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         if (start_i)
         begin
            left_q  <= len_i;
            busy_q  <= 1'b1;
            count_o <= {CNT_W{1'b0}};
         end
         else if (busy_q)
         begin
            count_o <= count_o + {{(CNT_W-1){1'b0}}, sample_i};
            left_q  <= left_q - {{(LEN_W-1){1'b0}}, 1'b1};
            if (left_q == {{(LEN_W-1){1'b0}}, 1'b1})
            begin
               busy_q <= 1'b0;
               done_o <= 1'b1;
            end
         end
      end
   end

endmodule // srtc_accum
`default_nettype wire

// [srtc_sysref_cal_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module srtc_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wr_en_i,
   input wire logic        rd_en_i,
   input wire logic [11:0] addr_i,
   input wire logic [7:0]  wdata_i,
   input wire logic [7:0]  rdata_o,
   input wire logic        sysref_i,
   input wire logic [16:0] delay_o,
   input wire logic        cal_fail_o
);
   logic [7:0]  en_q;
   logic [7:0]  cfg_q;
   logic [16:0] man_q;
   logic [16:0] dly_q;
   logic [1:0]  qt_q;
   logic        chg_q;
   wire         hit;
   assign hit = wr_en_i && (addr_i == 12'h2b0 || addr_i > 12'h2b4
                            && addr_i < 12'h2b8);
   // Mirrors the writable bytes; qt_q counts quiet cycles after a write to the enable or delay bytes.
   always @(posedge clk_i)
   begin
      dly_q <= delay_o;
      if (rst_i)
      begin
         en_q  <= 8'h00;
         cfg_q <= 8'h05;
         man_q <= 17'h00000;
         qt_q  <= 2'd0;
      end
      else
      begin
         if (wr_en_i && addr_i == 12'h2b0) en_q <= wdata_i;
         if (wr_en_i && addr_i == 12'h2b1) cfg_q <= wdata_i;
         if (wr_en_i && addr_i == 12'h2b5) man_q[7:0] <= wdata_i;
         if (wr_en_i && addr_i == 12'h2b6) man_q[15:8] <= wdata_i;
         if (wr_en_i && addr_i == 12'h2b7) man_q[16] <= wdata_i[0];
         qt_q <= hit ? 2'd0 : (qt_q == 2'd3 ? 2'd3 : qt_q + 2'd1);
      end
      if (rst_i || !en_q[0]) chg_q <= 1'b0;
      else if (delay_o != dly_q) chg_q <= 1'b1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_reset_state: assert property (disable iff (1'b0)
      rst_i |=> rdata_o == 8'h00 && delay_o == 17'h0 && !cal_fail_o)
      else $error("outputs not cleared by reset");
   a_manual_path: assert property (
      !en_q[0] && qt_q == 2'd3 |-> delay_o == man_q)
      else $error("delay differs from manual value");
   a_unmapped_zero: assert property (
      rd_en_i && (addr_i < 12'h2b0 || addr_i > 12'h2b7) |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!rd_en_i |=> $stable(rdata_o))
      else $error("read data moved without a read");
   a_cfg_read: assert property (
      rd_en_i && addr_i == 12'h2b1 |=> rdata_o == $past(cfg_q))
      else $error("config readback wrong");
   a_enable_read: assert property (
      rd_en_i && addr_i == 12'h2b0 |=> rdata_o == $past(en_q))
      else $error("enable readback wrong");
   a_fail_clear: assert property (
      !en_q[0] && qt_q == 2'd3 |-> !cal_fail_o)
      else $error("fail flag set while disabled");
   a_fail_holds: assert property (
      cal_fail_o && en_q[0] && !wr_en_i |=> cal_fail_o)
      else $error("fail flag dropped while enabled");
   a_result_holds: assert property (
      en_q[0] && chg_q |=> $stable(delay_o))
      else $error("result moved while enabled");
   c_fail: cover property ($rose(cal_fail_o));
   c_result: cover property ($rose(chg_q));
   c_unmapped: cover property (rd_en_i && addr_i == 12'h2a0);
endmodule // srtc_chk
bind srtc_sysref_cal srtc_chk u_srtc_chk (.clk_i, .rst_i, .wr_en_i,
   .rd_en_i, .addr_i, .wdata_i, .rdata_o, .sysref_i, .delay_o, .cal_fail_o);
`default_nettype wire

// [srtc_sysref_src.sv]
`timescale 1ns/100ps
`default_nettype none
module srtc_sysref_src (
   input  wire logic        clk_i,
   input  wire logic        run_i,
   input  wire logic [15:0] period_i,
   output var  logic        sysref_o
);
   logic [15:0] cnt_q = 16'h0000;
   initial sysref_o = 1'b0;
   // Periodic reference, high for half the period, low when stopped.
   always @(posedge clk_i)
   begin
      if (!run_i || cnt_q >= period_i - 16'd1) cnt_q <= 16'h0000;
      else cnt_q <= cnt_q + 16'd1;
      sysref_o <= run_i && cnt_q < (period_i >> 1);
   end
endmodule // srtc_sysref_src
`default_nettype wire

// [srtc_sysref_cal_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module srtc_sysref_cal_bench;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wr_en_i = 1'b0;
   logic        rd_en_i = 1'b0;
   logic [11:0] addr_i = 12'h000;
   logic [7:0]  wdata_i = 8'h00;
   logic [7:0]  rdata_o;
   logic [16:0] delay_o;
   logic        cal_fail_o;
   logic        sysref_i;
   logic        run = 1'b0;
   logic [15:0] period = 16'd100;
   logic [7:0]  d;
   logic [7:0]  cfgs [5] = '{8'h00, 8'h05, 8'h0a, 8'h0c, 8'h03};
   int          failures = 0;
   int          tests_run = 0;
   int          n;
   // Duration base shortened from 384 * 19 so the bound is reachable.
   localparam int BASE = 64;
   srtc_sysref_cal #(.BOUND_BASE(BASE)) u_srtc_sysref_cal (.clk_i, .rst_i,
      .wr_en_i, .rd_en_i,
      .addr_i, .wdata_i, .rdata_o, .sysref_i, .delay_o, .cal_fail_o);
   srtc_sysref_src u_srtc_sysref_src (.clk_i, .run_i(run),
      .period_i(period), .sysref_o(sysref_i));
   initial
   begin
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic chk(input logic [16:0] g, input logic [16:0] e);
      tests_run++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk_i);
      wr_en_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_en_i <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge clk_i);
      rd_en_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_en_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic wrap_up;
      if (failures == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Runs one calibration and polls status for up to the duration bound plus 16 cycles, at most 32768.
   // A zero period keeps the reference stopped.
   task automatic cal(input logic [7:0] cfg, input logic [15:0] per);
      int lim;
      lim = BASE * 4 ** (cfg[3:2] + cfg[1:0] + 2) + 16;
      if (lim > 32768)
         lim = 32768;
      period <= per;
      run <= (per != 16'd0);
      wr(12'h2b1, cfg);
      wr(12'h2b0, 8'h01);
      d = 8'h00;
      for (n = 0; n < lim && d[1] !== 1'b1 && cal_fail_o !== 1'b1; n += 2)
         rd(12'h2b4);
      if (n >= lim)
      begin
         failures++;
         wrap_up();
      end
   endtask
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(12'h2b0);
      chk(d, 8'h00);
      rd(12'h2b1);
      chk(d, 8'h05);
      wr(12'h2b3, 8'h5a);
      rd(12'h2b3);
      chk(d, 8'h00);
      rd(12'h2a0);
      chk(d, 8'h00);
      wr(12'h2b5, 8'ha5);
      wr(12'h2b6, 8'h3c);
      wr(12'h2b7, 8'h01);
      repeat (3) @(posedge clk_i);
      #1 chk(delay_o, 17'h13ca5);
      foreach (cfgs[i])
      begin
         cal(cfgs[i], 16'd100);
         chk(d[1], 1'b1);
         if (cfgs[i][1:0] < 2'd2) chk(d, 8'h03);
         chk(cal_fail_o, 1'b0);
         rd(12'h2b2);
         if (cfgs[i][1:0] < 2'd2) chk(d, 8'hff);
         wr(12'h2b0, 8'h01);
         wr(12'h2b5, 8'h00);
         rd(12'h2b4);
         chk(d[1], 1'b1);
         if (cfgs[i][1:0] < 2'd2) chk(delay_o[7:0], 8'hff);
         wr(12'h2b0, 8'h00);
         rd(12'h2b4);
         chk(d[1], 1'b0);
         chk(delay_o, 17'h13c00);
      end
      cal(8'h00, 16'd300);
      chk(cal_fail_o, 1'b1);
      wr(12'h2b0, 8'h00);
      repeat (2) @(posedge clk_i);
      #1 chk(cal_fail_o, 1'b0);
      cal(8'h00, 16'd0);
      chk(cal_fail_o, 1'b1);
      chk(d[1], 1'b0);
      wrap_up();
   end
endmodule // srtc_sysref_cal_bench
`default_nettype wire
